/* File: design/pss_pkg.sv */
package pss_pkg;

	typedef enum logic [2:0] {
		ST_OFF,
		ST_OFF_TO_ACTIVE_SEQ,
		ST_ACTIVE,
		ST_ACTIVE_TO_SLEEP_SEQ,
		ST_SLEEP,
		ST_SLEEP_TO_ACTIVE_SEQ,
		ST_TO_OFF
	} pss_state_t;

	typedef enum logic [2:0] {
		SQ_NONE,
		SQ_OFF_TO_ACTIVE_SEQ,
		SQ_ACTIVE_TO_OFF_SEQ,
		SQ_ACTIVE_TO_SLEEP_SEQ,
		SQ_SLEEP_TO_ACTIVE_SEQ,
		SQ_SLEEP_TO_OFF_SEQ
	} pss_seq_t;

endpackage

/* File: design/pss_power_ctl.sv */
// Behaviour
// - OFF requests outrank all other requests; only the ADC shutdown event can be masked.
// - OFF completes despite SLEEP or ON; ON served only once OFF sources clear.
// - One switch-off delay of 0, 1, 2 or 4 seconds shared by delayed sources.
// - Reaching OFF applies the configured full or partial register reset.
// - Each OFF source selects shutdown or cold restart.
// - Shutdown runs sleep-to-off or active-to-off, then stays OFF.
// - Cold restart goes OFF, then off-to-active unless ON is gated.
// - Watchdog off after reset; software may enable, then lock against changes.
// - Device-on bit and hold pin switch off only when neither keeps alive.
// - SLEEP request starts active-to-sleep only with no unmasked interrupt pending.
// - WAKE comes only from an interrupt, the sleep pin going inactive or the sleep mask bit being set.
// - WAKE acts only in SLEEP, starting sleep-to-active; sleep-to-off comes from OFF requests.
// - Each resource's active and sleep behaviour comes from its own settings.
// - Sleep-pin resources change mode through the sequenced transitions.
// - Direct-pin resources change mode at once when that pin changes.
// - Resources on both pins sleep only when the direct pin is inactive and the sleep sequence has completed.
// - Both pin polarities configurable; defaults direct high, sleep pin low.
// - All direct-pin-only resources switch together.
// - Sleep-pin-only resources switch together when the sleep sequence completes.
// - Resources on neither pin never sleep.
// - ON powers up only without low supply, overtemperature, power-down or reset.
// - In hold acknowledge mode the hold pin falling low is an OFF request.
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

module pss_power_ctl #(
	parameter int unsigned SEC_CYCLES = `PSS_SEC_CYC
) (
	input  wire logic                hclk,
	input  wire logic                hresetn,
	input  wire logic                hsel,
	input  wire logic [31:0]         haddr,
	input  wire logic [1:0]          htrans,
	input  wire logic                hwrite,
	input  wire logic [2:0]          hsize,
	input  wire logic [31:0]         hwdata,
	input  wire logic                hready,
	output logic                     hreadyout,
	output logic [31:0]              hrdata,
	output logic                     hresp,
	input  wire logic                on_request,
	input  wire logic                power_button_in,
	input  wire logic                power_down_in,
	input  wire logic                reset_in,
	input  wire logic                thermal_shutdown,
	input  wire logic                supply_low_event,
	input  wire logic                adc_shutdown_event,
	input  wire logic                hold_power_in,
	input  wire logic                sleep_request_n,
	input  wire logic                direct_mode_ctl,
	input  wire logic                supply_below_high,
	input  wire logic                die_overtemp,
	input  wire logic                irq_pending,
	input  wire logic                irq_wake,
	input  wire logic                seq_done,
	output logic                     seq_start,
	output pss_pkg::pss_seq_t        seq_sel,
	output pss_pkg::pss_state_t      power_state,
	output logic [`PSS_NRES-1:0]     res_sleep,
	output logic [`PSS_NRES-1:0]     res_on,
	output logic                     full_register_reset,
	output logic                     partial_register_reset
);
	import pss_pkg::*;

	pss_state_t                state_r;
	pss_seq_t                  seq_sel_r;
	logic                      seq_start_r;
	logic                      wr_pend_r;
	logic [7:0]                wa_r;
	logic [31:0]               rdata_r;
	logic [31:0]               rdata_nxt;
	logic                      wr;
	logic [`PSS_CTRL_W-1:0]    ctrl_r;
	logic [`PSS_NSRC-1:0]      lvl_r;
	logic [`PSS_NSRC-1:0]      act_r;
	logic                      wd_en_r;
	logic                      wd_lock_r;
	logic [3:0]                wd_per_r;
	logic [3:0]                wd_sec_r;
	logic [`PSS_NRES-1:0]      slp_asn_r;
	logic [`PSS_NRES-1:0]      dir_asn_r;
	logic [`PSS_NRES-1:0]      act_on_r;
	logic [`PSS_NRES-1:0]      slp_on_r;
	logic [31:0]               sec_cnt_r;
	logic                      sec_tick;
	logic [31:0]               dly_cyc_r;
	logic [31:0]               dly_target;
	logic [2:0]                dly_sec;
	logic                      dly_done;
	logic [`PSS_NSRC-1:0]      src;
	logic [`PSS_NSRC-1:0]      pend_r;
	logic [`PSS_NSRC-1:0]      fire_vec;
	logic [3:0]                win_idx;
	logic [3:0]                off_src_r;
	logic                      off_fire;
	logic                      running;
	logic                      keep_live;
	logic                      keep_seen_r;
	logic                      keep_drop;
	logic                      wd_expire;
	logic                      on_gated;
	logic                      sleep_act;
	logic                      dir_act;
	logic                      wake;
	logic                      seq_slp_r;
	logic                      restart_r;
	logic                      full_lvl_r;
	logic                      reg_full_r;
	logic                      reg_part_r;

	// Zero wait state slave, always OKAY
	assign hreadyout = 1'b1;
	assign hresp     = 1'b0;
	assign hrdata    = rdata_r;
	assign wr        = wr_pend_r;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wr_pend_r <= 1'b0;
			wa_r      <= 8'h00;
			rdata_r   <= 32'h0000_0000;
		end
		else if (hsel && hready && htrans[1])
		begin
			wr_pend_r <= hwrite;
			wa_r      <= haddr[7:0];
			rdata_r   <= hwrite ? 32'h0000_0000 : rdata_nxt;
		end
		else
			wr_pend_r <= 1'b0;
	end

	always_comb
	begin
		rdata_nxt = 32'h0000_0000;
		case (haddr[7:0])
			`PSS_CTRL_OFS:   rdata_nxt = {21'h0, ctrl_r};
			`PSS_OFFCFG_OFS: rdata_nxt = {6'h0, act_r, 6'h0, lvl_r};
			`PSS_WDOG_OFS:   rdata_nxt = {24'h0, wd_per_r, 2'b00, wd_lock_r, wd_en_r};
			`PSS_SLPASN_OFS: rdata_nxt = {24'h0, slp_asn_r};
			`PSS_DIRASN_OFS: rdata_nxt = {24'h0, dir_asn_r};
			`PSS_MODE_OFS:   rdata_nxt = {16'h0, slp_on_r, act_on_r};
			`PSS_STAT_OFS:
				rdata_nxt = {6'h0, pend_r, res_sleep, off_src_r, seq_slp_r, state_r};
			default:         rdata_nxt = 32'h0000_0000;
		endcase
	end

	// Control bits; the register reset chosen at OFF arrival also lands here
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			ctrl_r <= `PSS_CTRL_RST;
		else if (reg_full_r)
			ctrl_r <= `PSS_CTRL_RST;
		else
		begin
			if (wr && wa_r == `PSS_CTRL_OFS)
				ctrl_r <= hwdata[`PSS_CTRL_W-1:0];
			if (reg_part_r)
			begin
				ctrl_r[`PSS_C_DEVON] <= 1'b0;
				ctrl_r[`PSS_C_SWRST] <= 1'b0;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			lvl_r     <= `PSS_LVL_RST;
			act_r     <= `PSS_ACT_RST;
			slp_asn_r <= '0;
			dir_asn_r <= '0;
			{slp_on_r, act_on_r} <= `PSS_MODE_RST;
		end
		else if (reg_full_r)
		begin
			lvl_r     <= `PSS_LVL_RST;
			act_r     <= `PSS_ACT_RST;
			slp_asn_r <= '0;
			dir_asn_r <= '0;
			{slp_on_r, act_on_r} <= `PSS_MODE_RST;
		end
		else if (wr)
		begin
			case (wa_r)
				`PSS_OFFCFG_OFS:
				begin
					lvl_r <= hwdata[`PSS_NSRC-1:0];
					act_r <= hwdata[`PSS_NSRC+15:16];
				end
				`PSS_SLPASN_OFS: slp_asn_r <= hwdata[`PSS_NRES-1:0];
				`PSS_DIRASN_OFS: dir_asn_r <= hwdata[`PSS_NRES-1:0];
				`PSS_MODE_OFS:   {slp_on_r, act_on_r} <= hwdata[15:0];
				default:         ;
			endcase
		end
	end

	// Watchdog: once locked only a kick gets through
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			wd_en_r   <= 1'b0;
			wd_lock_r <= 1'b0;
			wd_per_r  <= `PSS_WPER_RST;
		end
		else if (reg_full_r)
		begin
			wd_en_r   <= 1'b0;
			wd_lock_r <= 1'b0;
			wd_per_r  <= `PSS_WPER_RST;
		end
		else if (wr && wa_r == `PSS_WDOG_OFS && !wd_lock_r)
		begin
			wd_en_r   <= hwdata[`PSS_W_EN];
			wd_lock_r <= hwdata[`PSS_W_LOCK];
			wd_per_r  <= hwdata[`PSS_W_PER];
		end
	end

	assign sec_tick = (sec_cnt_r == SEC_CYCLES - 1);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			sec_cnt_r <= 32'h0000_0000;
		else if (sec_tick)
			sec_cnt_r <= 32'h0000_0000;
		else
			sec_cnt_r <= sec_cnt_r + 32'h0000_0001;
	end

	assign running   = (state_r != ST_OFF);
	assign wd_expire = wd_en_r && running && (wd_sec_r == wd_per_r);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			wd_sec_r <= 4'h0;
		else if (!wd_en_r || !running || (wr && wa_r == `PSS_WDOG_OFS && hwdata[`PSS_W_KICK]))
			wd_sec_r <= 4'h0;
		else if (sec_tick && !wd_expire)
			wd_sec_r <= wd_sec_r + 4'h1;
	end

	// Keep-alive: device-on bit or, in acknowledge mode, the hold pin
	assign keep_live = ctrl_r[`PSS_C_DEVON] | (ctrl_r[`PSS_C_HOLDACK] & hold_power_in);
	assign keep_drop = keep_seen_r & ~keep_live;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			keep_seen_r <= 1'b0;
		else if (!running)
			keep_seen_r <= 1'b0;
		else if (state_r == ST_ACTIVE && keep_live)
			keep_seen_r <= 1'b1;
	end

	always_comb
	begin
		src    = '0;
		src[0] = power_button_in;
		src[1] = power_down_in ^ ctrl_r[`PSS_C_PDPOL];
		src[2] = wd_expire;
		src[3] = thermal_shutdown;
		src[4] = reset_in ^ ctrl_r[`PSS_C_RIPOL];
		src[5] = ctrl_r[`PSS_C_SWRST];
		src[6] = keep_drop & ~ctrl_r[`PSS_C_HOLDACK];
		src[7] = supply_low_event;
		src[8] = keep_drop & ctrl_r[`PSS_C_HOLDACK];
		src[9] = adc_shutdown_event & ~ctrl_r[`PSS_C_ADCMSK];
	end

	// Latched so a short pulse still completes its delay
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			pend_r <= '0;
		else if (!running)
			pend_r <= '0;
		else
			pend_r <= pend_r | src;
	end

	always_comb
	begin
		case (ctrl_r[`PSS_C_DLY])
			2'd0:    dly_sec = 3'd0;
			2'd1:    dly_sec = 3'd1;
			2'd2:    dly_sec = 3'd2;
			default: dly_sec = 3'd4;
		endcase
	end

	assign dly_target = 32'(SEC_CYCLES * 32'(dly_sec));
	assign dly_done   = (dly_cyc_r >= dly_target);

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			dly_cyc_r <= 32'h0000_0000;
		else if (!running || !(|(pend_r & `PSS_DLY_SRC)))
			dly_cyc_r <= 32'h0000_0000;
		else if (!dly_done)
			dly_cyc_r <= dly_cyc_r + 32'h0000_0001;
	end

	// Immediate sources bypass the shared delay
	always_comb
	begin
		if (|(pend_r & ~`PSS_DLY_SRC))
			fire_vec = pend_r & ~`PSS_DLY_SRC;
		else if (dly_done)
			fire_vec = pend_r & `PSS_DLY_SRC;
		else
			fire_vec = '0;
	end

	assign off_fire = |fire_vec;

	always_comb
	begin
		win_idx = 4'h0;
		for (int i = `PSS_NSRC - 1; i >= 0; i--)
			if (fire_vec[i])
				win_idx = 4'(i);
	end

	assign on_gated  = supply_below_high | die_overtemp | src[1] | src[4];
	assign dir_act   = direct_mode_ctl ^ ctrl_r[`PSS_C_DIRPOL];
	assign sleep_act = ~ctrl_r[`PSS_C_SLPMSK] &
	                   (sleep_request_n == ctrl_r[`PSS_C_SLPPOL]);
	assign wake      = irq_wake | ~sleep_act;

	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			state_r     <= ST_OFF;
			seq_sel_r   <= SQ_NONE;
			seq_start_r <= 1'b0;
			restart_r   <= 1'b0;
			full_lvl_r  <= 1'b0;
			off_src_r   <= 4'h0;
			reg_full_r  <= 1'b0;
			reg_part_r  <= 1'b0;
		end
		else
		begin
			seq_start_r <= 1'b0;
			reg_full_r  <= 1'b0;
			reg_part_r  <= 1'b0;
			if ((state_r == ST_ACTIVE || state_r == ST_SLEEP) && off_fire)
			begin
				state_r     <= ST_TO_OFF;
				seq_start_r <= 1'b1;
				seq_sel_r   <= (state_r == ST_SLEEP) ? SQ_SLEEP_TO_OFF_SEQ : SQ_ACTIVE_TO_OFF_SEQ;
				restart_r   <= act_r[win_idx];
				full_lvl_r  <= lvl_r[win_idx];
				off_src_r   <= win_idx;
			end
			else
			begin
				case (state_r)
					ST_OFF:
						// Live OFF sources hold the device down
						if (!(|src) && !on_gated && (on_request || restart_r))
						begin
							state_r     <= ST_OFF_TO_ACTIVE_SEQ;
							seq_start_r <= 1'b1;
							seq_sel_r   <= SQ_OFF_TO_ACTIVE_SEQ;
							restart_r   <= 1'b0;
						end
					ST_OFF_TO_ACTIVE_SEQ, ST_SLEEP_TO_ACTIVE_SEQ:
						if (seq_done)
							state_r <= ST_ACTIVE;
					ST_ACTIVE:
						if (sleep_act && !irq_pending)
						begin
							state_r     <= ST_ACTIVE_TO_SLEEP_SEQ;
							seq_start_r <= 1'b1;
							seq_sel_r   <= SQ_ACTIVE_TO_SLEEP_SEQ;
						end
					ST_ACTIVE_TO_SLEEP_SEQ:
						if (seq_done)
							state_r <= ST_SLEEP;
					ST_SLEEP:
						if (wake)
						begin
							state_r     <= ST_SLEEP_TO_ACTIVE_SEQ;
							seq_start_r <= 1'b1;
							seq_sel_r   <= SQ_SLEEP_TO_ACTIVE_SEQ;
						end
					ST_TO_OFF:
						if (seq_done)
						begin
							state_r    <= ST_OFF;
							reg_full_r <= full_lvl_r;
							reg_part_r <= ~full_lvl_r;
						end
					default:
						state_r <= ST_OFF;
				endcase
			end
		end
	end

	// Sequenced sleep flag flips only on the controller's own transitions
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
			seq_slp_r <= 1'b0;
		else if (!running)
			seq_slp_r <= 1'b0;
		else if (state_r == ST_ACTIVE_TO_SLEEP_SEQ && seq_done)
			seq_slp_r <= 1'b1;
		else if (state_r == ST_SLEEP && !off_fire && wake)
			seq_slp_r <= 1'b0;
	end

	// Sleep-pin-only resources all follow the sequenced sleep flag together
	wire logic [`PSS_NRES-1:0]  sl_vec;

	for (genvar g = 0; g < `PSS_NRES; g++)
	begin : g_res
		logic sl;
		always_comb
		begin
			case ({dir_asn_r[g], slp_asn_r[g]})
				2'b00:   sl = 1'b0;
				2'b01:   sl = seq_slp_r;
				2'b10:   sl = ~dir_act;
				default: sl = seq_slp_r & ~dir_act;
			endcase
		end
		assign sl_vec[g] = sl;
	end

	// One process owns both vectors; per-bit processes would split the drivers
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			res_sleep <= '0;
			res_on    <= '0;
		end
		else
		begin
			res_sleep <= sl_vec;
			res_on    <= {`PSS_NRES{running}} &
			             ((sl_vec & slp_on_r) | (~sl_vec & act_on_r));
		end
	end

	assign seq_start              = seq_start_r;
	assign seq_sel                = seq_sel_r;
	assign power_state            = state_r;
	assign full_register_reset    = reg_full_r;
	assign partial_register_reset = reg_part_r;

endmodule // pss_power_ctl

`default_nettype wire

/* File: design/pss_regs.svh */
`ifndef PSS_REGS_SVH
`define PSS_REGS_SVH

`define PSS_NRES        8
`define PSS_NSRC        10

`define PSS_CTRL_OFS    8'h00
`define PSS_OFFCFG_OFS  8'h04
`define PSS_WDOG_OFS    8'h08
`define PSS_SLPASN_OFS  8'h0C
`define PSS_DIRASN_OFS  8'h10
`define PSS_MODE_OFS    8'h14
`define PSS_STAT_OFS    8'h18

`define PSS_C_DLY       1:0
`define PSS_C_DEVON     2
`define PSS_C_SWRST     3
`define PSS_C_SLPMSK    4
`define PSS_C_SLPPOL    5
`define PSS_C_DIRPOL    6
`define PSS_C_HOLDACK   7
`define PSS_C_ADCMSK    8
`define PSS_C_PDPOL     9
`define PSS_C_RIPOL     10
`define PSS_CTRL_W      11
`define PSS_CTRL_RST    11'h010

`define PSS_W_EN        0
`define PSS_W_LOCK      1
`define PSS_W_KICK      2
`define PSS_W_PER       7:4
`define PSS_WPER_RST    4'hF

`define PSS_LVL_RST     10'h2BF
`define PSS_ACT_RST     10'h000
`define PSS_MODE_RST    16'hFFFF
`define PSS_DLY_SRC     10'h217

`define PSS_CLK_NS      20
`define PSS_SEC_NS      1_000_000_000
`define PSS_SEC_CYC     (`PSS_SEC_NS / `PSS_CLK_NS)

`endif

/* File: test/pss_power_ctl_chk.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

module pss_power_ctl_chk #(
	parameter int unsigned SEC_CYCLES = 20
) (
	input wire logic			hclk,
	input wire logic			hresetn,
	input wire logic			hreadyout,
	input wire logic			hresp,
	input wire logic			thermal_shutdown,
	input wire logic			supply_below_high,
	input wire logic			die_overtemp,
	input wire logic			irq_pending,
	input wire logic			seq_done,
	input wire logic			seq_start,
	input wire pss_pkg::pss_seq_t		seq_sel,
	input wire pss_pkg::pss_state_t	power_state,
	input wire logic [`PSS_NRES-1:0]	res_on,
	input wire logic			full_register_reset,
	input wire logic			partial_register_reset
);
	import pss_pkg::*;

	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);

	a_bus_okay:
	assert property (hreadyout && !hresp) else $error("bus stalled or error response");
	a_off_first:
	assert property ($rose(thermal_shutdown) && power_state == ST_ACTIVE
		|-> ##[2:3] power_state == ST_TO_OFF) else $error("thermal off not taken");
	a_off_seq:
	assert property (seq_start && power_state == ST_TO_OFF
		|-> seq_sel == SQ_ACTIVE_TO_OFF_SEQ || seq_sel == SQ_SLEEP_TO_OFF_SEQ) else $error("wrong off sequence");
	a_off_arrive:
	assert property (power_state == ST_TO_OFF && seq_done |=> power_state == ST_OFF
		&& (full_register_reset != partial_register_reset)) else $error("off arrival bad");
	a_reset_pulse:
	assert property (full_register_reset || partial_register_reset
		|-> power_state == ST_OFF && $past(power_state) == ST_TO_OFF)
		else $error("register reset outside off arrival");
	a_off_dark:
	assert property (power_state == ST_OFF && $past(power_state) == ST_OFF |-> res_on == '0)
		else $error("resource on in off state");
	a_on_gated:
	assert property (power_state == ST_OFF && (supply_below_high || die_overtemp)
		&& $past(supply_below_high || die_overtemp) |=> power_state == ST_OFF)
		else $error("power up while gated");
	a_no_sleep:
	assert property (power_state == ST_ACTIVE && irq_pending && $past(irq_pending)
		&& $past(irq_pending, 2) |=> power_state != ST_ACTIVE_TO_SLEEP_SEQ)
		else $error("sleep with interrupt pending");
	a_wake_gate:
	assert property (power_state == ST_SLEEP
		|=> power_state inside {ST_SLEEP, ST_SLEEP_TO_ACTIVE_SEQ, ST_TO_OFF}) else $error("bad sleep exit");
	a_start_up:
	assert property (power_state == ST_OFF_TO_ACTIVE_SEQ && $past(power_state) == ST_OFF
		|-> seq_start && seq_sel == SQ_OFF_TO_ACTIVE_SEQ) else $error("power up not started");
	a_start_sleep:
	assert property (power_state == ST_ACTIVE_TO_SLEEP_SEQ && $past(power_state) == ST_ACTIVE
		|-> seq_start && seq_sel == SQ_ACTIVE_TO_SLEEP_SEQ) else $error("sleep sequence not started");
endmodule // pss_power_ctl_chk

bind pss_power_ctl pss_power_ctl_chk #(
	.SEC_CYCLES(SEC_CYCLES)
) u_chk (
	.hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
	.thermal_shutdown(thermal_shutdown), .supply_below_high(supply_below_high),
	.die_overtemp(die_overtemp), .irq_pending(irq_pending), .seq_done(seq_done),
	.seq_start(seq_start), .seq_sel(seq_sel), .power_state(power_state), .res_on(res_on),
	.full_register_reset(full_register_reset),
	.partial_register_reset(partial_register_reset)
);
`default_nettype wire

/* File: test/pss_power_ctl_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`include "pss_regs.svh"

module pss_power_ctl_tb;
	import pss_pkg::*;

	localparam int SEC = 20;
	logic			hclk;
	logic			hresetn;
	logic			hsel;
	logic [31:0]		haddr;
	logic [1:0]		htrans;
	logic			hwrite;
	logic [2:0]		hsize;
	logic [31:0]		hwdata;
	logic			hreadyout;
	logic [31:0]		hrdata;
	logic			hresp;
	logic			on_request;
	logic [2:0]		src;
	logic [1:0]		gate;
	logic			hold_power_in;
	logic			sleep_request_n;
	logic			direct_mode_ctl;
	logic			irq_pending;
	logic			slow_seq;
	logic			seq_done;
	logic			seq_start;
	pss_seq_t		seq_sel;
	pss_state_t		power_state;
	logic [`PSS_NRES-1:0]	res_sleep;
	logic [`PSS_NRES-1:0]	res_on;
	logic			full_register_reset;
	logic			partial_register_reset;
	int			err_count;
	int			compares;

	// Source order: thermal, supply low, button
	pss_power_ctl #(.SEC_CYCLES(SEC)) dut (
		.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .on_request(on_request),
		.power_button_in(src[2]), .power_down_in(1'b0), .reset_in(1'b0),
		.thermal_shutdown(src[0]), .supply_low_event(src[1]), .adc_shutdown_event(1'b0),
		.hold_power_in(hold_power_in), .sleep_request_n(sleep_request_n),
		.direct_mode_ctl(direct_mode_ctl), .supply_below_high(gate[0]),
		.die_overtemp(gate[1]), .irq_pending(irq_pending), .irq_wake(1'b0),
		.seq_done(seq_done), .seq_start(seq_start), .seq_sel(seq_sel),
		.power_state(power_state), .res_sleep(res_sleep), .res_on(res_on),
		.full_register_reset(full_register_reset),
		.partial_register_reset(partial_register_reset)
	);

	pss_seq_model u_seq (
		.hclk(hclk), .hresetn(hresetn), .slow(slow_seq), .seq_start(seq_start),
		.seq_done(seq_done)
	);

	initial
	begin
		hclk = 1'b0;
		forever #10 hclk = ~hclk;
	end

	task automatic summarize();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic waitst(input pss_state_t s, input int lim, output int n);
		n = 0;
		while (power_state !== s && n < lim)
		begin
			@(posedge hclk);
			n++;
		end
		if (power_state !== s)
		begin
			chk(32'(power_state), 32'(s));
			summarize();
		end
	endtask

	task automatic edge_rdy();
		int n;
		n = 0;
		do
		begin
			@(posedge hclk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 20);
		if (hreadyout !== 1'b1)
		begin
			chk(32'(hreadyout), 32'h0000_0001);
			summarize();
		end
	endtask

	task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		haddr <= {24'h00_0000, a};
		hwrite <= wr;
		edge_rdy();
		htrans <= 2'b00;
		hwdata <= wd;
		edge_rdy();
		d = hrdata;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] dummy;
		ahb(1'b1, a, d, dummy);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] d;
		ahb(1'b0, a, 32'h0000_0000, d);
		chk(d, exp);
	endtask

	task automatic off_cycle(input int i, input int lim, output int n);
		int m;
		src[i] <= 1'b1;
		waitst(ST_TO_OFF, lim, n);
		chk(32'(seq_sel), 32'(SQ_ACTIVE_TO_OFF_SEQ));
		waitst(ST_OFF, 40, m);
		chk(32'(full_register_reset), 32'h0000_0001);
		repeat (5) @(posedge hclk);
		chk(32'(power_state), 32'(ST_OFF));
		chk(32'(res_on), 32'h0000_0000);
		src[i] <= 1'b0;
		waitst(ST_ACTIVE, 60, m);
	endtask

	initial
	begin
		int n;
		hresetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0000_0000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'b010;
		hwdata = 32'h0000_0000;
		on_request = 1'b0;
		src = 3'b000;
		gate = 2'b00;
		hold_power_in = 1'b0;
		sleep_request_n = 1'b1;
		direct_mode_ctl = 1'b1;
		irq_pending = 1'b0;
		slow_seq = 1'b0;
		err_count = 0;
		compares = 0;
		repeat (10) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		rd(`PSS_CTRL_OFS, 32'h0000_0010);
		rd(`PSS_OFFCFG_OFS, 32'h0000_02BF);
		rd(`PSS_WDOG_OFS, 32'h0000_00F0);
		rd(8'h1C, 32'h0000_0000);
		$display("test registers done");
		on_request <= 1'b1;
		for (int g = 0; g < 2; g++)
		begin
			gate[g] <= 1'b1;
			repeat (8) @(posedge hclk);
			chk(32'(power_state), 32'(ST_OFF));
			gate[g] <= 1'b0;
		end
		waitst(ST_OFF_TO_ACTIVE_SEQ, 20, n);
		chk(32'(seq_sel), 32'(SQ_OFF_TO_ACTIVE_SEQ));
		waitst(ST_ACTIVE, 40, n);
		$display("test power up done");
		for (int i = 0; i < 2; i++)
		begin
			off_cycle(i, 40, n);
			chk(32'(n <= 6), 32'h0000_0001);
		end
		// Slow sequencer here; its long answers come only after each delay count
		slow_seq <= 1'b1;
		for (int c = 0; c < 4; c++)
		begin
			wr(`PSS_CTRL_OFS, 32'h0000_0010 | c);
			off_cycle(2, 200, n);
			chk(32'(n >= SEC * (c == 3 ? 4 : c) + 3 && n <= SEC * (c == 3 ? 4 : c) + 7),
				32'h0000_0001);
		end
		slow_seq <= 1'b0;
		$display("test off requests done");
		wr(`PSS_DIRASN_OFS, 32'h0000_003F);
		wr(`PSS_SLPASN_OFS, 32'h0000_0070);
		wr(`PSS_MODE_OFS, 32'h0000_BFFF);
		direct_mode_ctl <= 1'b0;
		repeat (4) @(posedge hclk);
		chk(32'(res_sleep), 32'h0000_000F);
		direct_mode_ctl <= 1'b1;
		repeat (4) @(posedge hclk);
		chk(32'(res_sleep), 32'h0000_0000);
		wr(`PSS_CTRL_OFS, 32'h0000_0050);
		sleep_request_n <= 1'b0;
		repeat (4) @(posedge hclk);
		chk(32'(res_sleep), 32'h0000_000F);
		chk(32'(power_state), 32'(ST_ACTIVE));
		irq_pending <= 1'b1;
		wr(`PSS_CTRL_OFS, 32'h0000_0000);
		repeat (6) @(posedge hclk);
		chk(32'(power_state), 32'(ST_ACTIVE));
		irq_pending <= 1'b0;
		waitst(ST_ACTIVE_TO_SLEEP_SEQ, 20, n);
		chk(32'(seq_sel), 32'(SQ_ACTIVE_TO_SLEEP_SEQ));
		waitst(ST_SLEEP, 40, n);
		// Resource outputs trail the sleep flag by one register stage
		repeat (2) @(posedge hclk);
		chk(32'(res_sleep), 32'h0000_0040);
		chk(32'(res_on), 32'h0000_00BF);
		sleep_request_n <= 1'b1;
		waitst(ST_SLEEP_TO_ACTIVE_SEQ, 20, n);
		chk(32'(seq_sel), 32'(SQ_SLEEP_TO_ACTIVE_SEQ));
		waitst(ST_ACTIVE, 40, n);
		chk(32'(res_sleep), 32'h0000_0000);
		$display("test sleep done");
		on_request <= 1'b0;
		wr(`PSS_OFFCFG_OFS, 32'h0020_029F);
		wr(`PSS_CTRL_OFS, 32'h0000_0008);
		waitst(ST_TO_OFF, 20, n);
		waitst(ST_OFF, 40, n);
		chk(32'(partial_register_reset), 32'h0000_0001);
		waitst(ST_OFF_TO_ACTIVE_SEQ, 20, n);
		waitst(ST_ACTIVE, 40, n);
		$display("test cold restart done");
		wr(`PSS_CTRL_OFS, 32'h0000_0084);
		hold_power_in <= 1'b1;
		repeat (4) @(posedge hclk);
		wr(`PSS_CTRL_OFS, 32'h0000_0080);
		repeat (6) @(posedge hclk);
		chk(32'(power_state), 32'(ST_ACTIVE));
		hold_power_in <= 1'b0;
		waitst(ST_TO_OFF, 10, n);
		waitst(ST_OFF, 40, n);
		repeat (6) @(posedge hclk);
		chk(32'(power_state), 32'(ST_OFF));
		$display("test keep alive done");
		wr(`PSS_WDOG_OFS, 32'h0000_00F3);
		wr(`PSS_WDOG_OFS, 32'h0000_0000);
		rd(`PSS_WDOG_OFS, 32'h0000_00F3);
		$display("test watchdog lock done");
		summarize();
	end
endmodule // pss_power_ctl_tb
`default_nettype wire

/* File: test/pss_seq_model.sv */
`timescale 1ns/1ps
`default_nettype none

module pss_seq_model (
	input wire logic	hclk,
	input wire logic	hresetn,
	input wire logic	slow,
	input wire logic	seq_start,
	output logic		seq_done
);
	logic [7:0]	cnt_r;

	// Stored sequence length stands in for the resource steps
	always_ff @(posedge hclk or negedge hresetn)
	begin
		if (!hresetn)
		begin
			cnt_r <= 8'h00;
			seq_done <= 1'b0;
		end
		else
		begin
			seq_done <= (cnt_r == 8'h01);
			if (seq_start)
				cnt_r <= slow ? 8'h0C : 8'h02;
			else if (cnt_r != 8'h00)
				cnt_r <= cnt_r - 8'h01;
		end
	end
endmodule // pss_seq_model
`default_nettype wire
